// ---- verilog/obc_pkg.sv ----
// Purpose: Shared constants for the configuration byte decoder
// Assumes: Two 8-bit non-volatile configuration bytes
// Notes:   Field positions, defaults and cycle counts
package obc_pkg;
    // Byte 0 field positions
    localparam int B0_HALT_RST  = 7;
    localparam int B0_WDOG_SOFT = 6;
    localparam int B0_PROT_N    = 0;
    // Byte 1 field positions
    localparam int B1_PKG       = 7;
    localparam int B1_RST_LEN   = 6;
    localparam int B1_SRC_HI    = 5;
    localparam int B1_SRC_LO    = 4;
    localparam int B1_RNG_HI    = 3;
    localparam int B1_RNG_LO    = 1;
    localparam int B1_PLL_OFF   = 0;
    // Erased content and shipped defaults
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] DFLT_BYTE0  = 8'hFF;
    localparam logic [7:0] DFLT_BYTE1  = 8'hEF;
    // Reset-phase cycle counts
    localparam logic [12:0] RST_CYC_LONG  = 13'h1000;
    localparam logic [12:0] RST_CYC_SHORT = 13'h0100;
    // Clock source encodings
    typedef enum logic [1:0]
    {
        SRC_RESONATOR = 2'b00,
        SRC_RESERVED  = 2'b01,
        SRC_INT_RC    = 2'b10,
        SRC_EXTERNAL  = 2'b11
    } obc_src_t;
    // Frequency range encodings
    localparam logic [2:0] RANGE_1_2MHZ  = 3'h0;
    localparam logic [2:0] RANGE_2_4MHZ  = 3'h1;
    localparam logic [2:0] RANGE_4_8MHZ  = 3'h2;
    localparam logic [2:0] RANGE_8_16MHZ = 3'h3;
    // Loader sequencer
    typedef enum logic [1:0]
    {
        LD_IDLE  = 2'b00,
        LD_WIPE  = 2'b01,
        LD_DONE  = 2'b10
    } obc_ld_t;
endpackage

// ---- verilog/obc_store.sv ----
// Purpose: Non-volatile store model for the two configuration bytes
// Assumes: Access only while in programming mode
// Notes:   Erase returns both bytes to all ones
`timescale 1ns/100ps
`default_nettype none
module obc_store
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       prog_mode,
    input  wire logic       wr_en,
    input  wire logic       erase,
    input  wire logic       sel,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic      [7:0] byte0,
    output logic      [7:0] byte1
);
    import obc_pkg::*;

    logic [7:0] mem_r [2];
    wire        wr_ok = prog_mode & wr_en & ~erase;

    // Storage keeps shipped defaults out of reset; erase wins over write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_r[0] <= DFLT_BYTE0;
            mem_r[1] <= DFLT_BYTE1;
        end
        else if (prog_mode && erase)
        begin
            mem_r[0] <= ERASED_BYTE;
            mem_r[1] <= ERASED_BYTE;
        end
        else if (wr_ok)
        begin
            mem_r[sel] <= wr_data;
        end
    end

    // Read port only answers in programming mode
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rd_data <= 8'h00;
        else
            rd_data <= prog_mode ? mem_r[sel] : 8'h00;
    end

    assign byte0 = mem_r[0];
    assign byte1 = mem_r[1];
endmodule // obc_store
`default_nettype wire

// ---- verilog/obc_decode.sv ----
// Purpose: Decode configuration bytes into device-wide settings
// Assumes: 10 MHz clk, resetn async active low, rom_part is a strap
// Notes:   Settings latch once after reset release and then hold
// Function
// - Halt with active watchdog resets when byte0 bit7 is one
// - Byte0 bit6 zero makes watchdog always on; one lets software
// - Byte0 bit0 zero protects: block memory read-out and flash writes
// - Erasing bytes while protected wipes user memory first
// - Bytes unmapped; reachable only in programming mode
// - Blank content reads all ones; defaults all ones but source bit4
// - Flash parts ship with internal RC as clock source
// - Byte1 bit7 one means 44/48 pin package, zero 32 pin
// - Unbonded pads come up as pulled-up inputs after reset
// - Byte1 bit6 picks 4096 or 256 cycle reset and halt exit
// - Byte1 bits 5:4 pick resonator, reserved, RC or external clock
// - Byte1 bits 3:1 pick frequency range or resonator drive
// - Byte1 bit0 zero enables the x2 PLL
// - ROM parts fix values; protect bit polarity inverted
`timescale 1ns/100ps
`default_nettype none
module obc_decode
#(
    parameter logic [7:0] ROM_BYTE0 = 8'hFF,
    parameter logic [7:0] ROM_BYTE1 = 8'hEF,
    parameter int         PADS      = 8
)
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  rom_part,
    input  wire logic                  prog_mode,
    input  wire logic                  cfg_wr_en,
    input  wire logic                  cfg_erase,
    input  wire logic                  cfg_sel,
    input  wire logic [7:0]            cfg_wr_data,
    input  wire logic                  wipe_done,
    input  wire logic                  halt_entry,
    input  wire logic                  wdog_active,
    input  wire logic [PADS-1:0]       pad_bonded,
    output logic      [7:0]            cfg_rd_data,
    output logic                       user_mem_wipe,
    output logic                       wdog_reset_on_halt,
    output logic                       wdog_soft_select,
    output logic                       wdog_hw_enable,
    output logic                       halt_reset,
    output logic                       readout_protect,
    output logic                       flash_write_block,
    output logic                       package_select,
    output logic                       reset_cycle_select,
    output logic      [12:0]           reset_cycles,
    output obc_pkg::obc_src_t          clock_source_type,
    output logic      [2:0]            freq_range_select,
    output logic                       pll_enable,
    output logic                       cfg_invalid,
    output logic      [PADS-1:0]       pad_pullup_in,
    output logic                       settings_valid
);
    import obc_pkg::*;

    logic [7:0]  nv_b0;
    logic [7:0]  nv_b1;
    logic [7:0]  hold0_r;
    logic [7:0]  hold1_r;
    logic        strap_s1_r;
    logic        strap_s2_r;
    logic        rom_r;
    logic        valid_r;
    logic [1:0]  settle_r;
    obc_ld_t     ld_r;
    obc_ld_t     ld_nxt;
    logic [7:0]  fwd_wr_data;

    // Strap passes two flops before use
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end
        else
        begin
            strap_s1_r <= rom_part;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Erase while protected is held back until the user memory is wiped
    wire prot_now  = (nv_b0[B0_PROT_N] == 1'b0) & ~rom_r;
    wire erase_req = prog_mode & cfg_erase & ~rom_r;
    wire store_ers = (ld_r == LD_WIPE) & wipe_done;
    wire store_wr  = prog_mode & cfg_wr_en & ~rom_r & ~cfg_erase
                     & (ld_r == LD_IDLE);

    always_comb
    begin
        ld_nxt = ld_r;
        unique case (ld_r)
            LD_IDLE: if (erase_req)
                         ld_nxt = prot_now ? LD_WIPE : LD_DONE;
            LD_WIPE: if (wipe_done)
                         ld_nxt = LD_DONE;
            LD_DONE: if (!cfg_erase)
                         ld_nxt = LD_IDLE;
            default: ld_nxt = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ld_r <= LD_IDLE;
        else
            ld_r <= ld_nxt;
    end

    assign user_mem_wipe = (ld_r == LD_WIPE);
    assign fwd_wr_data   = cfg_wr_data;

    // Unprotected erase goes straight through; protected waits for wipe
    wire blank_req = store_ers | (erase_req & ~prot_now & (ld_r == LD_IDLE));

    obc_store u_store
    (
        .clk       (clk),
        .resetn    (resetn),
        .prog_mode (prog_mode),
        .wr_en     (store_wr),
        .erase     (blank_req),
        .sel       (cfg_sel),
        .wr_data   (fwd_wr_data),
        .rd_data   (cfg_rd_data),
        .byte0     (nv_b0),
        .byte1     (nv_b1)
    );

    // Capture waits two edges so the strap has crossed both flops;
    // capturing earlier would always see the reset value of the strap
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            settle_r <= 2'h0;
        else if (!settle_r[1])
            settle_r <= settle_r + 2'h1;
    end
    wire capture = settle_r[1] & ~valid_r;

    // Capture after release; ROM parts take fixed values, protect inverted
    wire [7:0] rom_b0 = ROM_BYTE0 ^ 8'h01;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold0_r <= DFLT_BYTE0;
            hold1_r <= DFLT_BYTE1;
            rom_r   <= 1'b0;
            valid_r <= 1'b0;
        end
        else if (capture)
        begin
            rom_r   <= strap_s2_r;
            hold0_r <= strap_s2_r ? rom_b0 : nv_b0;
            hold1_r <= strap_s2_r ? ROM_BYTE1 : nv_b1;
            valid_r <= 1'b1;
        end
    end

    // Byte 0 decoding
    assign wdog_reset_on_halt = hold0_r[B0_HALT_RST];
    assign wdog_soft_select   = hold0_r[B0_WDOG_SOFT];
    assign wdog_hw_enable     = ~hold0_r[B0_WDOG_SOFT];
    assign halt_reset = halt_entry & wdog_active & wdog_reset_on_halt;
    assign readout_protect    = ~hold0_r[B0_PROT_N];
    assign flash_write_block  = readout_protect;

    // Byte 1 decoding
    assign package_select     = hold1_r[B1_PKG];
    assign reset_cycle_select = hold1_r[B1_RST_LEN];
    assign reset_cycles = reset_cycle_select ? RST_CYC_SHORT
                                             : RST_CYC_LONG;
    assign clock_source_type =
        obc_src_t'(hold1_r[B1_SRC_HI:B1_SRC_LO]);
    assign freq_range_select = hold1_r[B1_RNG_HI:B1_RNG_LO];
    assign pll_enable        = ~hold1_r[B1_PLL_OFF];

    // Flags combinations the far side must avoid; settings still apply
    assign cfg_invalid = pll_enable &
        ((clock_source_type == SRC_EXTERNAL) & ~rom_r
         | (clock_source_type == SRC_INT_RC)
         | (freq_range_select != RANGE_2_4MHZ))
        | (clock_source_type == SRC_RESERVED);

    // Unbonded pads held as pulled-up inputs
    assign pad_pullup_in  = ~pad_bonded;
    assign settings_valid = valid_r;

    // Checks
    a_halt_reset: assert property (@(posedge clk) disable iff (!resetn)
        halt_reset == (halt_entry & wdog_active & hold0_r[7]))
        else $error("halt reset mismatch");
    a_wdog_type: assert property (@(posedge clk) disable iff (!resetn)
        wdog_hw_enable != wdog_soft_select)
        else $error("watchdog type mismatch");
    a_protect_block: assert property (@(posedge clk) disable iff (!resetn)
        readout_protect |-> flash_write_block)
        else $error("protect without write block");
    a_wipe_first: assert property (@(posedge clk) disable iff (!resetn)
        (ld_r == LD_IDLE && erase_req && prot_now) |=> user_mem_wipe
        && nv_b0 == $past(nv_b0))
        else $error("erase before wipe");
    a_prog_only: assert property (@(posedge clk) disable iff (!resetn)
        !prog_mode |=> $stable(nv_b0) && $stable(nv_b1))
        else $error("write outside programming mode");
    a_reset_cycles: assert property (@(posedge clk) disable iff (!resetn)
        reset_cycles == (hold1_r[6] ? 13'h0100 : 13'h1000))
        else $error("reset cycle count wrong");
    a_settings_hold: assert property (@(posedge clk) disable iff (!resetn)
        valid_r |=> $stable(hold0_r) && $stable(hold1_r))
        else $error("settings changed after capture");
    a_valid_once: assert property (@(posedge clk) disable iff (!resetn)
        (settle_r[1] && !valid_r) |=> valid_r)
        else $error("capture late");
    a_no_early: assert property (@(posedge clk) disable iff (!resetn)
        !settle_r[1] |-> !valid_r)
        else $error("capture before strap settled");
    a_pll_decode: assert property (@(posedge clk) disable iff (!resetn)
        pll_enable == !hold1_r[0])
        else $error("pll decode wrong");
    c_wipe: cover property (@(posedge clk) user_mem_wipe ##1 !user_mem_wipe);
    c_halt: cover property (@(posedge clk) halt_reset);
    c_rom: cover property (@(posedge clk) valid_r && rom_r);
    c_bad: cover property (@(posedge clk) cfg_invalid);
endmodule // obc_decode
`default_nettype wire

// ---- verif/obc_prog_tool.sv ----
// Purpose: Programming tool model for the configuration byte port
// Assumes: Acts just after a clock edge; write strobe lasts one cycle, erase lasts the hold count
// Notes:   Released data shows the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module obc_prog_tool
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic            prog_mode,
    output logic            wr_en,
    output logic            erase,
    output logic            sel,
    output logic      [7:0] wr_data
);
    // Idle: outside programming mode, no strobes
    initial
    begin
        prog_mode = 1'b0;
        wr_en     = 1'b0;
        erase     = 1'b0;
        sel       = 1'b0;
        wr_data   = 8'h5A;
    end
    // The tool never sends a PLL or reset-phase option the silicon cannot run; a reserved source still passes
    function automatic logic [7:0] legal(input logic s, input logic [7:0] d);
        logic [7:0] v;
        v = s ? d : (d | 8'h3E); // Byte0 reserved bits stay high
        if (s && v[5:4] == 2'b00)
            v[6] = 1'b0; // Resonator gets the long reset phase
        if (s && !(v[3:1] == 3'h1 && v[5:4] == 2'b00))
            v[0] = 1'b1; // PLL only 2-4 MHz, no RC or ext
        return v;
    endfunction
    task automatic set_mode(input logic m);
        @(posedge clk);
        prog_mode <= m;
    endtask
    task automatic write_byte(input logic s, input logic [7:0] d);
        @(posedge clk);
        sel     <= s;
        wr_data <= legal(s, d);
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        wr_data <= ~legal(s, d);
    endtask
    // Answer is registered: sample one edge after select lands
    task automatic read_byte(input logic s, output logic [7:0] d);
        @(posedge clk);
        sel <= s;
        @(posedge clk);
        #1 d = rd_data;
    endtask
    task automatic erase_all(input int hold);
        @(posedge clk);
        erase <= 1'b1;
        repeat (hold) @(posedge clk);
        erase <= 1'b0;
    endtask
endmodule // obc_prog_tool
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the configuration byte decoder
// Assumes: Flash part first, ROM strap after the second reset
// Notes:   Flash settings checked against shipped defaults, ROM set
//          against the fixed codes given at the instance
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import obc_pkg::*;
    logic clk, resetn, rom_part, wipe_done, halt_entry, wdog_active;
    logic prog_mode, cfg_wr_en, cfg_erase, cfg_sel, user_mem_wipe;
    logic wdog_reset_on_halt, wdog_soft_select, wdog_hw_enable, halt_reset;
    logic readout_protect, flash_write_block, package_select, pll_enable;
    logic reset_cycle_select, cfg_invalid, settings_valid;
    logic [7:0] pad_bonded, pad_pullup_in, cfg_wr_data, cfg_rd_data, rd;
    logic [12:0] reset_cycles;
    logic [2:0] freq_range_select;
    obc_src_t clock_source_type;
    int mismatches = 0;
    int checked = 0;
    // ROM codes chosen away from the flash defaults to reach other decodes
    obc_decode #(.ROM_BYTE0(8'h3F), .ROM_BYTE1(8'h02)) obc_decode_inst
        (.clk, .resetn, .rom_part, .prog_mode,
        .cfg_wr_en, .cfg_erase, .cfg_sel, .cfg_wr_data, .wipe_done,
        .halt_entry, .wdog_active, .pad_bonded, .cfg_rd_data, .user_mem_wipe,
        .wdog_reset_on_halt, .wdog_soft_select, .wdog_hw_enable, .halt_reset,
        .readout_protect, .flash_write_block, .package_select,
        .reset_cycle_select, .reset_cycles, .clock_source_type,
        .freq_range_select, .pll_enable, .cfg_invalid, .pad_pullup_in,
        .settings_valid);
    obc_prog_tool obc_prog_tool_inst (.clk, .rd_data(cfg_rd_data),
        .prog_mode, .wr_en(cfg_wr_en), .erase(cfg_erase), .sel(cfg_sel),
        .wr_data(cfg_wr_data));
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [12:0] e,
                       input logic [12:0] g);
        checked++;
        if (g !== e)
            $display("mismatch %s expected %h seen %h", nm, e, g);
        if (g !== e)
            mismatches++;
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Held settings must decode the shipped defaults
    task automatic t_defaults;
        chk("valid", 13'h1, settings_valid);
        chk("halt_opt", 13'(DFLT_BYTE0[B0_HALT_RST]), wdog_reset_on_halt);
        chk("soft", 13'h1, wdog_soft_select);
        chk("hw_en", 13'h0, wdog_hw_enable);
        chk("protect", 13'h0, readout_protect);
        chk("wr_block", 13'h0, flash_write_block);
        chk("pkg", 13'h1, package_select);
        chk("rst_sel", 13'h1, reset_cycle_select);
        chk("rst_cyc", RST_CYC_SHORT, reset_cycles);
        chk("src", 13'(SRC_INT_RC), 13'(clock_source_type));
        chk("range", 13'h7, 13'(freq_range_select));
        chk("pll", 13'h0, pll_enable);
        chk("invalid", 13'h0, cfg_invalid);
        chk("pads", 13'h0F0, 13'(pad_pullup_in));
    endtask
    // Release reset; settings stay invalid until the strap has settled
    task automatic release_reset;
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("settle", 13'h0, settings_valid);
        @(posedge clk);
        #1;
    endtask
    // Halt only resets with an active watchdog and the option set
    task automatic t_halt(input logic e);
        @(posedge clk);
        wdog_active <= 1'b1;
        halt_entry  <= 1'b1;
        @(negedge clk);
        chk("halt_rst", 13'(e), halt_reset);
        @(posedge clk);
        wdog_active <= 1'b0;
        @(negedge clk);
        chk("halt_idle", 13'h0, halt_reset);
        @(posedge clk);
        halt_entry  <= 1'b0;
    endtask
    // ROM strap: fixed codes, inverted protect polarity, writes refused
    task automatic t_rom;
        chk("rom_halt", 13'h0, wdog_reset_on_halt);
        chk("rom_soft", 13'h0, wdog_soft_select);
        chk("rom_hw_en", 13'h1, wdog_hw_enable);
        chk("rom_prot", 13'h1, readout_protect);
        chk("rom_block", 13'h1, flash_write_block);
        chk("rom_pkg", 13'h0, package_select);
        chk("rom_rst_sel", 13'h0, reset_cycle_select);
        chk("rom_rst", RST_CYC_LONG, reset_cycles);
        chk("rom_src", 13'(SRC_RESONATOR), 13'(clock_source_type));
        chk("rom_rng", 13'(RANGE_2_4MHZ), 13'(freq_range_select));
        chk("rom_pll", 13'h1, pll_enable);
        chk("rom_ok", 13'h0, cfg_invalid);
        t_halt(1'b0);
        obc_prog_tool_inst.write_byte(1'b1, 8'h02);
        obc_prog_tool_inst.read_byte(1'b1, rd);
        chk("rom_fixed", 13'(DFLT_BYTE1), 13'(rd));
    endtask
    // Access only in programming mode; settings stay until reset
    task automatic t_access;
        obc_prog_tool_inst.read_byte(1'b1, rd);
        chk("rd_off", 13'h0, 13'(rd));
        obc_prog_tool_inst.set_mode(1'b1);
        obc_prog_tool_inst.write_byte(1'b1, 8'h02);
        obc_prog_tool_inst.read_byte(1'b1, rd);
        chk("byte1", 13'h02, 13'(rd));
        obc_prog_tool_inst.write_byte(1'b0, 8'h3E);
        obc_prog_tool_inst.read_byte(1'b0, rd);
        chk("byte0", 13'h3E, 13'(rd));
        chk("src_held", 13'(SRC_INT_RC), 13'(clock_source_type));
        obc_prog_tool_inst.set_mode(1'b0);
        obc_prog_tool_inst.write_byte(1'b1, 8'hFF);
        obc_prog_tool_inst.set_mode(1'b1);
        obc_prog_tool_inst.read_byte(1'b1, rd);
        chk("refused", 13'h02, 13'(rd));
    endtask
    // Erase while protected wipes user memory before blanking
    task automatic t_erase;
        fork
            obc_prog_tool_inst.erase_all(6);
            begin
                repeat (4) @(posedge clk);
                wipe_done <= 1'b1;
                #1 chk("wipe", 13'h1, user_mem_wipe);
                @(posedge clk);
                wipe_done <= 1'b0;
                #1 chk("wipe_end", 13'h0, user_mem_wipe);
            end
        join
        obc_prog_tool_inst.read_byte(1'b0, rd);
        chk("blank0", 13'(ERASED_BYTE), 13'(rd));
        obc_prog_tool_inst.read_byte(1'b1, rd);
        chk("blank1", 13'(ERASED_BYTE), 13'(rd));
    endtask
    // Second reset drops the settings and recaptures them as a ROM part
    task automatic t_reset;
        @(posedge clk);
        resetn   <= 1'b0;
        rom_part <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("valid_rst", 13'h0, settings_valid);
        release_reset();
        t_rom();
    endtask
    initial
    begin
        {clk, resetn, rom_part, wipe_done, halt_entry, wdog_active} = '0;
        pad_bonded = 8'h0F;
        @(posedge clk);
        release_reset();
        t_defaults();
        t_halt(1'b1);
        t_access();
        t_erase();
        t_reset();
        complete_run();
    end
    // A hang ends the run as a failure
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
